// [hdl/i2c_restart_pkg.sv]
// Purpose: Shared constants, types and register layout of the I2C master
//          restart, transmit and receive engine.
// Assumes: One AHB-Lite slave, 32-bit data, each register one aligned word.
// Notes:   Offsets are byte addresses compared on the low eight bits.
`default_nettype none
package i2c_restart_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] BUF_OFS = 8'h08;
  localparam logic [7:0] BAUD_OFS = 8'h0c;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_RESTART_ENABLE_BIT = 0;
  localparam int CTRL_RECEIVE_ENABLE_BIT = 1;
  localparam int CTRL_ACK_VALUE_BIT = 2;
  localparam int STAT_BUSY = 7;
  localparam logic [6:0] STAT_W1C_MASK = 7'h66;
  localparam logic [7:0] BAUD_RESET = 8'h13;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Bit 0 is buffer_full, bit 6 is bus_collision.
  typedef struct packed {
    logic bus_collision;
    logic serial_event;
    logic start_seen;
    logic ack_status;
    logic receive_overflow;
    logic write_collision;
    logic buffer_full;
  } status_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_t;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_RS_LOW = 10'b00_0000_0010,
    ST_RS_SDA = 10'b00_0000_0100,
    ST_RS_SCL = 10'b00_0000_1000,
    ST_RS_HOLD = 10'b00_0001_0000,
    ST_RS_SDALO = 10'b00_0010_0000,
    ST_TX_LOW = 10'b00_0100_0000,
    ST_TX_HIGH = 10'b00_1000_0000,
    ST_RX_LOW = 10'b01_0000_0000,
    ST_RX_HIGH = 10'b10_0000_0000
  } state_t;

endpackage : i2c_restart_pkg
`default_nettype wire

// [hdl/i2c_master_restart_tx_rx.sv]
// Purpose: I2C master engine: repeated start, byte transmit with
//          acknowledge capture, byte receive with full and overflow flags.
// Assumes: Pin inputs are synchronous to clk_sys; open-drain pins are
//          resolved outside from the active-low enables.
// Notes:   Zero-wait AHB-Lite slave; every response is OKAY.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] Restart enable drives SCL low, then loads generator.
// [R2] Release SDA one period; release SCL if SDA high.
// [R3] Hold high, SDA low one period, SCL low.
// [R4] Start seen at once; event after timeout.
// [R5] Restart request ignored while another event runs.
// [R6] Restart collision: SDA low at rise, early SCL fall.
// [R7] Idle buffer write sets full, starts shifting.
// [R8] Any byte: data, address plus direction bit.
// [R9] SDA changes after SCL falls; low, high periods.
// [R10] After eighth bit clear full, release SDA.
// [R11] Ninth rising edge captures acknowledge status.
// [R12] After ninth clock set event, hold SCL low.
// [R13] Busy buffer write ignored, sets write collision.
// [R14] Receive request ignored unless module idle.
// [R15] Receive toggles SCL per rollover, shifts SDA in.
// [R16] Eighth receive bit: copy, flag, clear enable, idle.
// [R17] Reading the buffer clears buffer full.
// [R18] Byte completes while full sets receive overflow.
// [R19] Software orders start, address, data, stop/restart.
// [R20] Software receives byte, then acknowledges or stops.
// [R21] Software sets acknowledge value before acknowledge sequence.
// [R22] Loads take reload value; pause while SCL held low.
// [R23] Collision aborts, releases lines, clears enables, flags.
// [R24] Bytes move most significant bit first.
module i2c_master_restart_tx_rx (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // I2C clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  // I2C data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  i2c_restart_pkg::state_t state_q;
  i2c_restart_pkg::status_t stat_q;
  i2c_restart_pkg::ahb_req_t req_q;
  logic [7:0] baud_q, brg_q, tx_sr_q, rx_sr_q, rx_buf_q;
  logic [3:0] bit_cnt_q;
  logic hi_seen_q, sda_prev_q;
  logic restart_enable_bit_q, receive_enable_bit_q, ack_value_bit_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q, hresp_q;
  logic scl_oe_n_q, sda_oe_n_q, scl_out_q, sda_out_q;
  logic addr_phase, wr_ctrl, wr_stat, wr_buf, wr_baud, rd_buf;
  logic brg_done, collide, idle;
  logic [31:0] rd_word;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_ctrl = req_q.valid && req_q.write
                   && hit(req_q.addr, i2c_restart_pkg::CTRL_OFS);
  assign wr_stat = req_q.valid && req_q.write
                   && hit(req_q.addr, i2c_restart_pkg::STAT_OFS);
  assign wr_buf = req_q.valid && req_q.write
                  && hit(req_q.addr, i2c_restart_pkg::BUF_OFS);
  assign wr_baud = req_q.valid && req_q.write
                   && hit(req_q.addr, i2c_restart_pkg::BAUD_OFS);
  assign rd_buf = addr_phase && !hwrite
                  && hit(haddr[7:0], i2c_restart_pkg::BUF_OFS);
  assign idle = (state_q == i2c_restart_pkg::ST_IDLE);
  assign brg_done = (brg_q == 8'h00);

  // Repeated start collision: SDA low when SCL rises, or SCL pulled low
  // by someone else before we drive SDA low.
  assign collide =
    ((state_q == i2c_restart_pkg::ST_RS_SDA) && brg_done && !sda_in) ||
    ((state_q == i2c_restart_pkg::ST_RS_SCL) && scl_in && !sda_in) ||
    ((state_q == i2c_restart_pkg::ST_RS_HOLD) && !scl_in); // [R6]

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      i2c_restart_pkg::CTRL_OFS: begin
        rd_word[i2c_restart_pkg::CTRL_RESTART_ENABLE_BIT] = restart_enable_bit_q;
        rd_word[i2c_restart_pkg::CTRL_RECEIVE_ENABLE_BIT] = receive_enable_bit_q;
        rd_word[i2c_restart_pkg::CTRL_ACK_VALUE_BIT] = ack_value_bit_q;
      end
      i2c_restart_pkg::STAT_OFS: begin
        rd_word[6:0] = stat_q;
        rd_word[i2c_restart_pkg::STAT_BUSY] = !idle;
      end
      i2c_restart_pkg::BUF_OFS: rd_word[7:0] = rx_buf_q;
      i2c_restart_pkg::BAUD_OFS: rd_word[7:0] = baud_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Read data is latched at the address phase so it stands from a flop
  // for the whole data phase; the slave never inserts wait states.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      req_q <= '0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      req_q.valid <= addr_phase;
      req_q.write <= hwrite;
      req_q.addr <= haddr[7:0];
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata_q <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Engine: baud generator, sequencer, pins and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= i2c_restart_pkg::ST_IDLE;
      stat_q <= '0;
      baud_q <= i2c_restart_pkg::BAUD_RESET;
      brg_q <= 8'h00;
      tx_sr_q <= 8'h00;
      rx_sr_q <= 8'h00;
      rx_buf_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      hi_seen_q <= 1'b0;
      sda_prev_q <= 1'b1;
      restart_enable_bit_q <= 1'b0;
      receive_enable_bit_q <= 1'b0;
      ack_value_bit_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      sda_prev_q <= sda_in;
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
      // Clears come first so a hardware set in the same cycle wins.
      if (wr_stat) begin
        stat_q <= stat_q & ~(hwdata[6:0] & i2c_restart_pkg::STAT_W1C_MASK);
      end
      if (rd_buf) begin
        stat_q.buffer_full <= 1'b0; // [R17]
      end
      if (wr_baud) begin
        baud_q <= hwdata[7:0];
      end
      if (wr_ctrl) begin
        ack_value_bit_q <= hwdata[i2c_restart_pkg::CTRL_ACK_VALUE_BIT];
      end
      if (wr_buf && !idle) begin
        stat_q.write_collision <= 1'b1; // [R13]
      end
      if (scl_in && sda_prev_q && !sda_in) begin
        stat_q.start_seen <= 1'b1; // [R4]
      end else if (scl_in && !sda_prev_q && sda_in) begin
        stat_q.start_seen <= 1'b0;
      end
      if (!brg_done) begin
        brg_q <= brg_q - 8'h01;
      end
      case (state_q)
        i2c_restart_pkg::ST_IDLE: begin
          if (wr_buf) begin
            // Any byte goes out the same way; MSB leads. [R8] [R24]
            tx_sr_q <= hwdata[7:0];
            sda_oe_n_q <= hwdata[7]; // [R9]
            scl_oe_n_q <= 1'b0; // [R9]
            stat_q.buffer_full <= 1'b1; // [R7]
            brg_q <= baud_q;
            bit_cnt_q <= 4'h0;
            state_q <= i2c_restart_pkg::ST_TX_LOW;
          end else if (wr_ctrl && hwdata[i2c_restart_pkg::CTRL_RESTART_ENABLE_BIT]) begin
            restart_enable_bit_q <= 1'b1; // [R5]
            scl_oe_n_q <= 1'b0; // [R1]
            state_q <= i2c_restart_pkg::ST_RS_LOW;
          end else if (wr_ctrl && hwdata[i2c_restart_pkg::CTRL_RECEIVE_ENABLE_BIT]) begin
            receive_enable_bit_q <= 1'b1; // [R14]
            scl_oe_n_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            brg_q <= baud_q;
            bit_cnt_q <= 4'h0;
            state_q <= i2c_restart_pkg::ST_RX_LOW;
          end
        end
        i2c_restart_pkg::ST_RS_LOW: begin
          if (!scl_in) begin
            brg_q <= baud_q; // [R1]
            sda_oe_n_q <= 1'b1; // [R2]
            state_q <= i2c_restart_pkg::ST_RS_SDA;
          end
        end
        i2c_restart_pkg::ST_RS_SDA: begin
          if (brg_done && sda_in) begin
            scl_oe_n_q <= 1'b1; // [R2]
            state_q <= i2c_restart_pkg::ST_RS_SCL;
          end
        end
        i2c_restart_pkg::ST_RS_SCL: begin
          if (scl_in) begin
            brg_q <= baud_q; // [R2] [R22]
            state_q <= i2c_restart_pkg::ST_RS_HOLD;
          end
        end
        i2c_restart_pkg::ST_RS_HOLD: begin
          if (brg_done) begin
            sda_oe_n_q <= 1'b0; // [R3]
            brg_q <= baud_q;
            state_q <= i2c_restart_pkg::ST_RS_SDALO;
          end
        end
        i2c_restart_pkg::ST_RS_SDALO: begin
          if (brg_done) begin
            // The generator is left stopped and SDA stays low.
            scl_oe_n_q <= 1'b0; // [R3]
            restart_enable_bit_q <= 1'b0;
            stat_q.serial_event <= 1'b1; // [R4]
            state_q <= i2c_restart_pkg::ST_IDLE;
          end
        end
        i2c_restart_pkg::ST_TX_LOW, i2c_restart_pkg::ST_RX_LOW: begin
          if (brg_done) begin
            scl_oe_n_q <= 1'b1; // [R9] [R15]
            hi_seen_q <= 1'b0;
            brg_q <= baud_q;
            state_q <= (state_q == i2c_restart_pkg::ST_TX_LOW)
                       ? i2c_restart_pkg::ST_TX_HIGH
                       : i2c_restart_pkg::ST_RX_HIGH;
          end
        end
        i2c_restart_pkg::ST_TX_HIGH: begin
          if (!scl_in) begin
            brg_q <= baud_q; // [R22]
          end else if (!hi_seen_q) begin
            hi_seen_q <= 1'b1;
            brg_q <= baud_q;
            if (bit_cnt_q == i2c_restart_pkg::ACK_BIT) begin
              stat_q.ack_status <= sda_in; // [R11]
            end
          end else if (brg_done) begin
            scl_oe_n_q <= 1'b0; // [R9]
            if (bit_cnt_q == i2c_restart_pkg::ACK_BIT) begin
              // No reload: the generator rests until the next buffer write, restart or receive request.
              stat_q.serial_event <= 1'b1; // [R12]
              state_q <= i2c_restart_pkg::ST_IDLE;
            end else begin
              brg_q <= baud_q;
              bit_cnt_q <= bit_cnt_q + 4'h1;
              state_q <= i2c_restart_pkg::ST_TX_LOW;
              if (bit_cnt_q == i2c_restart_pkg::LAST_DATA_BIT) begin
                stat_q.buffer_full <= 1'b0; // [R10]
                sda_oe_n_q <= 1'b1;
              end else begin
                sda_oe_n_q <= tx_sr_q[6]; // [R24]
                tx_sr_q <= {tx_sr_q[6:0], 1'b0};
              end
            end
          end
        end
        i2c_restart_pkg::ST_RX_HIGH: begin
          if (!scl_in) begin
            brg_q <= baud_q; // [R22]
          end else if (!hi_seen_q) begin
            hi_seen_q <= 1'b1;
            brg_q <= baud_q;
            rx_sr_q <= {rx_sr_q[6:0], sda_in}; // [R15] [R24]
          end else if (brg_done) begin
            scl_oe_n_q <= 1'b0; // [R15]
            if (bit_cnt_q == i2c_restart_pkg::LAST_DATA_BIT) begin
              receive_enable_bit_q <= 1'b0; // [R16]
              rx_buf_q <= rx_sr_q;
              stat_q.buffer_full <= 1'b1;
              stat_q.serial_event <= 1'b1;
              if (stat_q.buffer_full) begin
                stat_q.receive_overflow <= 1'b1; // [R18]
              end
              state_q <= i2c_restart_pkg::ST_IDLE;
            end else begin
              brg_q <= baud_q;
              bit_cnt_q <= bit_cnt_q + 4'h1;
              state_q <= i2c_restart_pkg::ST_RX_LOW;
            end
          end
        end
        default: state_q <= i2c_restart_pkg::ST_IDLE;
      endcase
      // Abort overrides whatever the sequencer chose this cycle.
      if (collide) begin
        sda_oe_n_q <= 1'b1; // [R23]
        scl_oe_n_q <= 1'b1;
        restart_enable_bit_q <= 1'b0;
        receive_enable_bit_q <= 1'b0;
        stat_q.bus_collision <= 1'b1;
        brg_q <= 8'h00;
        state_q <= i2c_restart_pkg::ST_IDLE;
      end
    end
  end

  // Outputs come straight from their flops.
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign scl_out = scl_out_q;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_out = sda_out_q;
  assign sda_oe_n = sda_oe_n_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  rs_ignored_a: assert property (@(posedge clk_sys) // [R5]
    disable iff (!reset_n) wr_ctrl && hwdata[i2c_restart_pkg::CTRL_RESTART_ENABLE_BIT]
    && !idle && !restart_enable_bit_q |=> !restart_enable_bit_q)
    else $error("restart taken while busy");
  rs_end_a: assert property (@(posedge clk_sys) // [R3]
    disable iff (!reset_n) state_q == i2c_restart_pkg::ST_RS_SDALO
    && brg_done && !collide |=> !restart_enable_bit_q && !sda_oe_n_q
    && !scl_oe_n_q && stat_q.serial_event)
    else $error("restart did not end with both lines low");
  rs_collide_a: assert property (@(posedge clk_sys) // [R6]
    disable iff (!reset_n) state_q == i2c_restart_pkg::ST_RS_HOLD && !scl_in
    |=> stat_q.bus_collision && idle && scl_oe_n_q && sda_oe_n_q)
    else $error("early SCL fall not flagged as collision");
  tx_start_a: assert property (@(posedge clk_sys) // [R7]
    disable iff (!reset_n) wr_buf && idle |=> stat_q.buffer_full
    && state_q == i2c_restart_pkg::ST_TX_LOW && !scl_oe_n_q
    && sda_oe_n_q == $past(hwdata[7]))
    else $error("idle buffer write did not start transmit");
  write_collision_flag_busy_a: assert property (@(posedge clk_sys) // [R13]
    disable iff (!reset_n) wr_buf && !idle |=> stat_q.write_collision
    && (tx_sr_q == $past(tx_sr_q) || tx_sr_q == ($past(tx_sr_q) << 1)))
    else $error("busy buffer write not refused");
  ack_capture_a: assert property (@(posedge clk_sys) // [R11]
    disable iff (!reset_n) state_q == i2c_restart_pkg::ST_TX_HIGH
    && bit_cnt_q == i2c_restart_pkg::ACK_BIT && scl_in && !hi_seen_q
    |=> stat_q.ack_status == $past(sda_in))
    else $error("acknowledge not captured on ninth rise");
  rx_done_a: assert property (@(posedge clk_sys) // [R16]
    disable iff (!reset_n) state_q == i2c_restart_pkg::ST_RX_HIGH
    && bit_cnt_q == i2c_restart_pkg::LAST_DATA_BIT && hi_seen_q && scl_in
    && brg_done |=> !receive_enable_bit_q && stat_q.buffer_full
    && stat_q.serial_event && idle && !scl_oe_n_q
    && rx_buf_q == $past(rx_sr_q))
    else $error("receive completion incomplete");
  rx_overflow_a: assert property (@(posedge clk_sys) // [R18]
    disable iff (!reset_n) state_q == i2c_restart_pkg::ST_RX_HIGH
    && bit_cnt_q == i2c_restart_pkg::LAST_DATA_BIT && hi_seen_q && scl_in
    && brg_done && stat_q.buffer_full |=> stat_q.receive_overflow)
    else $error("overflow not flagged");
  scl_pause_a: assert property (@(posedge clk_sys) // [R22]
    disable iff (!reset_n) (state_q == i2c_restart_pkg::ST_TX_HIGH
     || state_q == i2c_restart_pkg::ST_RX_HIGH) && !scl_in |=>
    brg_q == $past(baud_q))
    else $error("generator counted while SCL held low");
  gen_idle_a: assert property (@(posedge clk_sys) // [R12]
    disable iff (!reset_n) idle |-> brg_done)
    else $error("baud generator running while idle");

endmodule : i2c_master_restart_tx_rx
`default_nettype wire

// [test/i2c_slave_model.sv]
// Purpose: Behavioural I2C slave facing the master engine.
// Assumes: Both lines are open drain with pull-ups, resolved in the bench.
// Notes:   Bit index follows SCL rises; data moves only while SCL is low.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Resolved lines and our pull-downs
  input wire logic scl,
  input wire logic sda,
  output logic scl_hold_n,
  output logic sda_pull_n,
  // Scenario controls
  input wire logic arm,
  input wire logic rx_mode,
  input wire logic give_ack,
  input wire logic jam_sda,
  input wire logic [7:0] send_byte,
  input wire logic [3:0] stretch,
  output logic [7:0] got_byte
);
  // --------------------------------------------------------------------
  // Line behaviour
  // --------------------------------------------------------------------
  logic scl_q;
  logic [3:0] rise_q;
  logic [3:0] hold_q;
  logic [3:0] bit_idx;
  logic drive_low;

  // Changing data during the high phase would look like a start or stop.
  assign bit_idx = scl_q ? rise_q - 4'h1 : rise_q;
  always_comb begin
    if (rx_mode) begin
      drive_low = (bit_idx < 4'h8) && !send_byte[3'h7 - bit_idx[2:0]];
    end else begin
      drive_low = give_ack && (bit_idx == 4'h8);
    end
  end
  assign sda_pull_n = !(drive_low || jam_sda);
  // Stretching the low phase makes the master wait for the real rise.
  assign scl_hold_n = (hold_q == 4'h0);

  always_ff @(posedge clk_sys) begin
    scl_q <= scl;
    if (!reset_n || arm) begin
      rise_q <= 4'h0;
      hold_q <= 4'h0;
    end else begin
      if (scl && !scl_q) begin
        rise_q <= rise_q + 4'h1;
        if (bit_idx < 4'h8) begin
          got_byte <= {got_byte[6:0], sda};
        end
      end
      if (!scl && scl_q) begin
        hold_q <= stretch;
      end else if (hold_q != 4'h0) begin
        hold_q <= hold_q - 4'h1;
      end
    end
  end
endmodule : i2c_slave_model
`default_nettype wire

// [test/tb.sv]
// Purpose: Self-checking bench for the I2C master restart, tx, rx engine.
// Assumes: AHB-Lite master with one slave; open-drain lines with pull-ups.
// Notes:   Baud reload is lowered to 4 so that each byte stays short.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic scl, sda, scl_hold_n, sda_pull_n;
  logic arm = 1'b0;
  logic rx_mode = 1'b0;
  logic give_ack = 1'b0;
  logic jam_sda = 1'b0;
  logic [7:0] send_byte = 8'h0;
  logic [3:0] stretch = 4'h0;
  logic [7:0] got_byte;
  int errors = 0;
  int compares = 0;

  always #4 clk_sys = ~clk_sys;
  assign scl = scl_oe_n & scl_hold_n;
  assign sda = sda_oe_n & sda_pull_n;

  i2c_master_restart_tx_rx dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n));
  i2c_slave_model slave_u (.clk_sys(clk_sys), .reset_n(reset_n), .scl(scl),
    .sda(sda), .scl_hold_n(scl_hold_n), .sda_pull_n(sda_pull_n), .arm(arm),
    .rx_mode(rx_mode), .give_ack(give_ack), .jam_sda(jam_sda),
    .send_byte(send_byte), .stretch(stretch), .got_byte(got_byte));

  // --------------------------------------------------------------------
  // Bus and check helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    htrans <= 2'h2;
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ofs, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] ofs, output logic [31:0] v);
    bus(1'b0, ofs, 32'h0, v);
  endtask : rd

  task automatic wait_flag(input int pos, output logic [31:0] st);
    int n;
    n = 0;
    st = 32'h0;
    while (st[pos] !== 1'b1 && n < 3000) begin
      rd(i2c_restart_pkg::STAT_OFS, st);
      n++;
    end
    chk({31'h0, st[pos]}, 32'h1, "status flag wait");
  endtask : wait_flag

  task automatic arm_slave(input logic rx, input logic ack,
                           input logic [7:0] b, input logic jam,
                           input logic [3:0] st);
    @(posedge clk_sys);
    rx_mode <= rx;
    give_ack <= ack;
    send_byte <= b;
    jam_sda <= jam;
    stretch <= st;
    arm <= 1'b1;
    @(posedge clk_sys);
    arm <= 1'b0;
  endtask : arm_slave

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] v;
    rd(i2c_restart_pkg::CTRL_OFS, v);
    chk(v, 32'h0, "ctrl reset");
    rd(i2c_restart_pkg::STAT_OFS, v);
    chk(v, 32'h0, "status reset");
    rd(i2c_restart_pkg::BAUD_OFS, v);
    chk(v, {24'h0, i2c_restart_pkg::BAUD_RESET}, "baud reset");
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, v);
    chk(v, 32'h0, "unmapped");
    wr(i2c_restart_pkg::BAUD_OFS, 32'h4);
    rd(i2c_restart_pkg::BAUD_OFS, v);
    chk(v, 32'h4, "baud write");
    wr(i2c_restart_pkg::CTRL_OFS, 32'h4);
    rd(i2c_restart_pkg::CTRL_OFS, v);
    chk(v, 32'h4, "ack value");
  endtask : t_regs

  task automatic t_restart(input logic jam);
    logic [31:0] v;
    arm_slave(1'b0, 1'b0, 8'h0, jam, 4'h0);
    wr(i2c_restart_pkg::CTRL_OFS, 32'h1);
    if (!jam) begin
      wait_flag(5, v);
      chk({31'h0, v[4]}, 32'h1, "start seen");
      chk({31'h0, v[6]}, 32'h0, "no collision");
      chk({30'h0, scl, sda}, 32'h0, "lines low");
    end else begin
      wait_flag(6, v);
      chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3, "released");
      arm_slave(1'b0, 1'b0, 8'h0, 1'b0, 4'h0);
    end
    rd(i2c_restart_pkg::CTRL_OFS, v);
    chk({31'h0, v[0]}, 32'h0, "restart clear");
    chk({30'h0, scl_out, sda_out}, 32'h0, "pin data low");
    wr(i2c_restart_pkg::STAT_OFS, 32'h66);
  endtask : t_restart

  task automatic t_tx(input logic [7:0] b, input logic ack,
                      input logic [3:0] st);
    logic [31:0] v;
    arm_slave(1'b0, ack, 8'h0, 1'b0, st);
    wr(i2c_restart_pkg::BUF_OFS, {24'h0, b});
    rd(i2c_restart_pkg::STAT_OFS, v);
    chk({30'h0, v[7], v[0]}, 32'h3, "busy and full");
    wr(i2c_restart_pkg::BUF_OFS, {24'h0, ~b});
    wr(i2c_restart_pkg::CTRL_OFS, 32'h3);
    wait_flag(5, v);
    chk({31'h0, v[1]}, 32'h1, "write collision");
    chk({31'h0, v[0]}, 32'h0, "full cleared");
    chk({31'h0, v[3]}, {31'h0, !ack}, "ack status");
    chk({24'h0, got_byte}, {24'h0, b}, "byte on wire");
    chk({30'h0, scl, sda_oe_n}, 32'h1, "scl low sda free");
    rd(i2c_restart_pkg::CTRL_OFS, v);
    chk({30'h0, v[1:0]}, 32'h0, "busy requests");
    wr(i2c_restart_pkg::STAT_OFS, 32'h66);
    rd(i2c_restart_pkg::STAT_OFS, v);
    chk(v & 32'h66, 32'h0, "flags cleared");
  endtask : t_tx

  task automatic t_rx(input logic [7:0] b, input logic ov,
                      input logic rd_it);
    logic [31:0] v;
    arm_slave(1'b1, 1'b0, b, 1'b0, 4'h0);
    wr(i2c_restart_pkg::CTRL_OFS, 32'h2);
    rd(i2c_restart_pkg::CTRL_OFS, v);
    chk({31'h0, v[1]}, 32'h1, "receive on");
    wr(i2c_restart_pkg::BUF_OFS, 32'h0);
    wait_flag(5, v);
    chk({29'h0, v[2:0]}, {29'h0, ov, 2'h3}, "rx flags");
    chk({31'h0, scl}, 32'h0, "scl held");
    rd(i2c_restart_pkg::CTRL_OFS, v);
    chk({31'h0, v[1]}, 32'h0, "receive off");
    if (rd_it) begin
      rd(i2c_restart_pkg::BUF_OFS, v);
      if (!ov) begin
        chk(v, {24'h0, b}, "rx byte");
      end
      rd(i2c_restart_pkg::STAT_OFS, v);
      chk({31'h0, v[0]}, 32'h0, "read clears");
    end
    wr(i2c_restart_pkg::STAT_OFS, 32'h66);
  endtask : t_rx

  task automatic report_and_stop;
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs;
    t_restart(1'b0);
    t_tx(8'ha5, 1'b1, 4'h0);
    t_tx(8'h3c, 1'b0, 4'h9);
    t_rx(8'h96, 1'b0, 1'b1);
    t_rx(8'h3c, 1'b0, 1'b0);
    t_rx(8'hc3, 1'b1, 1'b1);
    t_restart(1'b1);
    t_restart(1'b0);
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
